// File: hdl/ncb_bridge.sv
/*
 host bridge of a network card: sequencer, page and control bits,
 shared ram arbitration by ready withdrawal, id prom, interrupt latch.
 assumes pin bundles come from outside clk and are synchronised here.
*/
// What this block does
// - control bit0 drives controller reset, set at reset
// - control bit1 drives loopback, cleared at reset
// - writing one to bit2 emits attention pulse
// - writing one to bit3 clears interrupt latch
// - upper twelve control write bits are ignored
// - ram window upper half, rest lower half
// - four bit page picks 4 KB page
// - ram is 32K by 16, optional 8K
// - controller sees contiguous ram, high bits undecoded only in the 8K build
// - controller address captured on latch strobe
// - upper byte driver off while mask active
// - one write strobe, lowest address bit ignored
// - 32 byte prom, byte data, word aligned
// - interrupt shows as flag, fiq reads zero
// - bytes nine to fourteen hold station address
// - host access stalls controller by withdrawing ready
// - sequencer idle then three states on select
// - ready withdrawn three cycles on every access
// - controller interrupt latched, cleared by reset or bit3
`timescale 1ns/1ps
module ncb_bridge
	import ncb_pkg::*;
#(
	parameter bit SMALL_RAM = 1'b0  // build option for 8K by 16
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire ncb_slot_type slot_pins,
	input  wire ncb_net_type  net_pins,
	output logic      [15:0]  slot_data_out,
	output logic              slot_data_oe_n,
	output logic      [15:0]  net_ad_out,
	output logic      [1:0]   net_ad_oe_n,
	output logic              net_ready,
	output logic              controller_reset_out,
	output logic              loopback_select_bit,
	output logic              attention_pulse,
	output logic              card_irq_n
);
	localparam int RAM_WORDS = SMALL_RAM ? RAM_WORDS_SMALL : RAM_WORDS_FULL;
	localparam int AW = $clog2(RAM_WORDS);

	// two flop synchronisers for both pin bundles
	ncb_slot_type slot_m_q;   // first stage, read only by slot_q
	ncb_slot_type slot_q;     // safe copy
	ncb_net_type  net_m_q;    // first stage, read only by net_q
	ncb_net_type  net_q;      // safe copy

	// sequencer and registers
	ncb_state_type state_q;   // current access state
	ncb_state_type state_d;   // next access state
	logic [3:0]    page_q;    // ram_page_select
	logic          rst_q;     // controller reset bit
	logic          loop_q;    // loopback bit
	logic          att_q;     // attention pulse flop
	logic          irq_q;     // latched controller interrupt
	logic          irq_d;
	logic          intr_q;    // previous interrupt level
	logic          ale_q;     // previous latch strobe level
	logic [15:0]   net_addr_q; // captured controller address
	logic          ready_q;
	logic [15:0]   sdata_q;   // host read data
	logic          soe_n_q;
	logic [15:0]   nad_q;     // controller read data
	logic [1:0]    noe_n_q;
	logic          irq_n_q;

	// synchronise everything coming from pins
	// reset loads idle levels: an all ones value here would show a rising
	// latch strobe and interrupt at the first edge, against a zero history
	// flop, and latch a phantom interrupt and address right after reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			slot_m_q <= SLOT_IDLE;
			slot_q   <= SLOT_IDLE;
			net_m_q  <= NET_IDLE;
			net_q    <= NET_IDLE;
		end else begin
			slot_m_q <= slot_pins;
			slot_q   <= slot_m_q;
			net_m_q  <= net_pins;
			net_q    <= net_m_q;
		end
	end

	// host address decode
	wire       in_idle  = (state_q == st_idle);
	wire       in_sa2   = (state_q == st_sa2);
	wire       in_sa3   = (state_q == st_sa3);
	wire       host_ram = slot_q.addr[SEL_RAM_BIT];
	wire [1:0] low_sel  = slot_q.addr[LOW_SEL_MSB:LOW_SEL_LSB];
	wire       host_wr  = in_sa2 && !slot_q.write_n;
	wire       ctrl_wr  = host_wr && !host_ram && (low_sel == CTRL_SEL);
	wire       page_wr  = host_wr && !host_ram && (low_sel == PAGE_SEL);
	wire       ram_hwr  = host_wr && host_ram;
	wire       prom_hit = !host_ram && (low_sel == PROM_SEL);
	wire       rd_hit   = slot_q.write_n && (host_ram || prom_hit);   // write_n high = read
	wire [3:0] ctrl_in  = slot_q.wdata[CTRL_BITS-1:0];

	// page register picks which 4 KB page appears in the window
	wire [AW-1:0] host_word = AW'({page_q, slot_q.addr[WIN_MSB:0]});

	// controller word address, AD0 dropped, high bits dropped only in the 8K build
	wire [AW-1:0] net_word  = AW'(net_addr_q[15:1]);

	// controller strobes
	wire net_rd   = !net_q.rd_n;
	wire net_wr   = !net_q.wr_n;
	wire ale_rise = net_q.ale && !ale_q;
	wire int_rise = net_q.intr && !intr_q;

	// ram port: host owns it only in sa2, controller only in idle
	wire          ram_we    = ram_hwr || (in_idle && net_wr);
	wire [AW-1:0] ram_addr  = in_sa2 ? host_word : net_word;
	wire [15:0]   ram_wdata = in_sa2 ? slot_q.wdata : net_q.ad;
	wire [15:0]   ram_rdata;
	wire [7:0]    prom_rdata;

	// interrupt latch: a new edge wins over a clear in the same cycle
	wire iclr = ctrl_wr && ctrl_in[CTRL_ICLR_BIT];
	always_comb begin
		irq_d = irq_q;
		if (int_rise) begin
			irq_d = 1'b1;
		end else if (iclr) begin
			irq_d = 1'b0;
		end
	end

	// sequencer runs one pass per slot select
	always_comb begin
		state_d = state_q;
		case (state_q)
			st_idle: begin
				if (!slot_q.sel_n) begin
					state_d = st_sa1;
				end
			end
			st_sa1: begin
				state_d = st_sa2;
			end
			st_sa2: begin
				state_d = st_sa3;
			end
			st_sa3: begin
				state_d = st_idle;
			end
			default: begin
				state_d = st_idle;
			end
		endcase
	end

	// state and ready; ready low for the three access states
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= st_idle;
			ready_q <= 1'b1;
		end else begin
			state_q <= state_d;
			ready_q <= (state_d == st_idle);
		end
	end

	// page register, written in sa2 only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			page_q <= PAGE_RESET;
		end else if (page_wr) begin
			page_q <= ctrl_in;
		end
	end

	// control bits; the upper write bits never reach a flop
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_q  <= RST_RESET;
			loop_q <= LOOP_RESET;
		end else if (ctrl_wr) begin
			rst_q  <= ctrl_in[CTRL_RST_BIT];
			loop_q <= ctrl_in[CTRL_LOOP_BIT];
		end
	end

	// attention: one cycle pulse, clears itself
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			att_q <= 1'b0;
		end else begin
			att_q <= ctrl_wr && ctrl_in[CTRL_ATT_BIT];
		end
	end

	// interrupt latch and edge history
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_q   <= 1'b0;
			irq_n_q <= 1'b1;
			intr_q  <= 1'b0;
		end else begin
			irq_q   <= irq_d;
			irq_n_q <= !irq_d;
			intr_q  <= net_q.intr;
		end
	end

	// controller address phase capture on the strobe's rising edge
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ale_q      <= 1'b0;
			net_addr_q <= 16'h0000;
		end else begin
			ale_q <= net_q.ale;
			if (ale_rise) begin
				net_addr_q <= net_q.ad;
			end
		end
	end

	// host read data: ram or prom word, driven the cycle after sa3
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sdata_q <= 16'h0000;
			soe_n_q <= 1'b1;
		end else begin
			soe_n_q <= !(in_sa3 && rd_hit);
			if (in_sa3) begin
				sdata_q <= host_ram ? ram_rdata : {8'h00, prom_rdata};
			end
		end
	end

	// controller read data; upper byte held off while masked
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			nad_q   <= 16'h0000;
			noe_n_q <= 2'h3;
		end else begin
			nad_q      <= ram_rdata;
			noe_n_q[0] <= !net_rd;
			noe_n_q[1] <= !(net_rd && net_q.bim_n);
		end
	end

	ncb_ram #(
		.WORDS (RAM_WORDS),
		.WIDTH (16)
	) u_ram (
		.clk    (clk),
		.arst_n (arst_n),
		.addr   (ram_addr),
		.we     (ram_we),
		.wdata  (ram_wdata),
		.rdata  (ram_rdata)
	);

	// word aligned byte prom, index from low word address bits
	ncb_prom u_prom (
		.clk      (clk),
		.arst_n   (arst_n),
		.index    (slot_q.addr[4:0]),
		.irq_flag (irq_q),
		.rdata    (prom_rdata)
	);

	// outputs straight from flops
	assign slot_data_out        = sdata_q;
	assign slot_data_oe_n       = soe_n_q;
	assign net_ad_out           = nad_q;
	assign net_ad_oe_n          = noe_n_q;
	assign net_ready            = ready_q;
	assign controller_reset_out = rst_q;
	assign loopback_select_bit  = loop_q;
	assign attention_pulse      = att_q;
	assign card_irq_n           = irq_n_q;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence access_walk;
		state_q == st_sa1 ##1 state_q == st_sa2 ##1 state_q == st_sa3;
	endsequence

	sequence ready_gap;
		!net_ready [*3] ##1 net_ready;
	endsequence

	seq_walk_a: assert property (
		(in_idle && !slot_q.sel_n) |=> access_walk ##1 in_idle)
		else $error("sequencer did not walk sa1 sa2 sa3 idle");

	ready_three_a: assert property (
		(state_q == st_sa1) |-> ready_gap)
		else $error("ready not withdrawn for exactly three cycles");

	ctrl_reset_a: assert property (
		ctrl_wr |=> controller_reset_out == $past(slot_q.wdata[CTRL_RST_BIT]))
		else $error("reset bit did not follow control write");

	loop_bit_a: assert property (
		ctrl_wr |=> loopback_select_bit == $past(slot_q.wdata[CTRL_LOOP_BIT]))
		else $error("loopback bit did not follow control write");

	att_pulse_a: assert property (
		(ctrl_wr && slot_q.wdata[CTRL_ATT_BIT]) |=> attention_pulse ##1 !attention_pulse)
		else $error("attention pulse not one cycle");

	att_cause_a: assert property (
		attention_pulse |-> $past(ctrl_wr && slot_q.wdata[CTRL_ATT_BIT]))
		else $error("attention pulse without a write of one");

	irq_clear_a: assert property (
		(iclr && !int_rise) |=> card_irq_n)
		else $error("interrupt not withdrawn by clear");

	irq_hold_a: assert property (
		(!card_irq_n && !iclr) |=> !card_irq_n)
		else $error("interrupt dropped without clear");

	page_load_a: assert property (
		page_wr |=> page_q == $past(slot_q.wdata[3:0]))
		else $error("page register not loaded");

	net_block_a: assert property (
		(ram_we && !in_sa2) |-> (in_idle && net_ready))
		else $error("controller wrote ram while stalled");

	stall_ready_a: assert property (
		!in_idle |-> !net_ready)
		else $error("ready high during a host access");

	host_read_a: assert property (
		(in_sa3 && rd_hit) |=> !slot_data_oe_n ##1 slot_data_oe_n)
		else $error("read enable not one cycle after sa3");

	upper_mask_a: assert property (
		!net_q.bim_n |=> net_ad_oe_n[1])
		else $error("upper byte driven while masked");
endmodule : ncb_bridge

// File: pkg/ncb_pkg.sv
/*
 net card host bridge: shared constants, states and pin bundles.
 assumes one clock domain; pin bundles are synchronised inside the bridge.
*/
package ncb_pkg;
	// control bit positions
	localparam int CTRL_RST_BIT = 0;
	localparam int CTRL_LOOP_BIT = 1;
	localparam int CTRL_ATT_BIT = 2;
	localparam int CTRL_ICLR_BIT = 3;
	localparam int CTRL_BITS = 4;
	// values after reset
	localparam logic [3:0] PAGE_RESET = 4'h0;
	localparam logic RST_RESET = 1'b1;
	localparam logic LOOP_RESET = 1'b0;
	// host address decode within slot word address
	localparam int SEL_RAM_BIT = 11;
	localparam int LOW_SEL_MSB = 10;
	localparam int LOW_SEL_LSB = 9;
	localparam int WIN_MSB = 10;
	localparam logic [1:0] PROM_SEL = 2'h0;
	localparam logic [1:0] PAGE_SEL = 2'h1;
	localparam logic [1:0] CTRL_SEL = 2'h2;
	// ram geometry
	localparam int RAM_WORDS_FULL = 32768;
	localparam int RAM_WORDS_SMALL = 8192;
	// id prom layout
	localparam int PROM_BYTES = 32;
	localparam int PROM_FLAG_OFS = 5'h00;
	localparam int PROM_ID_OFS = 5'h03;
	localparam int PROM_REV_OFS = 5'h08;
	localparam int PROM_STN_OFS = 5'h09;
	localparam int PROM_HI_OFS = 5'h10;
	localparam int PROM_CRC_OFS = 5'h1C;
	localparam int PROM_IRQ_BIT = 0;
	localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
	localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;

	// host access sequencer
	typedef enum logic [1:0] {st_idle, st_sa1, st_sa2, st_sa3} ncb_state_type;

	// slot side pins
	typedef struct packed {
		logic        sel_n;   // slot_select, low active
		logic        write_n; // low for write
		logic [11:0] addr;    // slot_addr_bus
		logic [15:0] wdata;   // slot_data_bus in
	} ncb_slot_type;

	// network controller side pins
	typedef struct packed {
		logic        ale;     // address latch strobe
		logic        rd_n;
		logic        wr_n;
		logic        bim_n;   // upper_byte_mask_n
		logic        intr;    // edge style interrupt
		logic [15:0] ad;      // net_addr_data_bus in
	} ncb_net_type;

	// idle pin levels loaded into the synchronisers at reset, so that the
	// strobe and interrupt edge detectors see no false edge on release
	localparam ncb_slot_type SLOT_IDLE = '{sel_n: 1'b1, write_n: 1'b1,
		addr: 12'h000, wdata: 16'h0000};
	localparam ncb_net_type  NET_IDLE  = '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1,
		bim_n: 1'b1, intr: 1'b0, ad: 16'h0000};
endpackage : ncb_pkg

// File: hdl/ncb_ram.sv
/*
 single port word ram shared by host and controller.
 assumes the caller muxes address and strobe; read data is registered.
*/
`timescale 1ns/1ps
module ncb_ram #(
	parameter int WORDS = 32768,
	parameter int WIDTH = 16
) (
	input  wire logic                     clk,
	input  wire logic                     arst_n,
	input  wire logic [$clog2(WORDS)-1:0] addr,
	input  wire logic                     we,
	input  wire logic [WIDTH-1:0]         wdata,
	output logic      [WIDTH-1:0]         rdata
);
	logic [WIDTH-1:0] mem [WORDS];  // storage, no reset
	logic [WIDTH-1:0] rdata_q;      // registered read

	// one strobe writes both bytes
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	// read data from a flop
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= mem[addr];
		end
	end

	assign rdata = rdata_q;
endmodule : ncb_ram

// File: hdl/ncb_prom.sv
/*
 32 byte identity prom with built in crc.
 assumes the host index is stable for the cycle before data is used.
*/
`timescale 1ns/1ps
module ncb_prom
	import ncb_pkg::*;
#(
	parameter logic [7:0]  CARD_ID   = 8'h5A,             // arbitrary value
	parameter logic [7:0]  PCB_REV   = 8'h02,             // arbitrary value
	parameter logic [47:0] STATION   = 48'h0200_0000_0001 // arbitrary value
) (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic [4:0] index,
	input  wire logic       irq_flag,
	output logic      [7:0] rdata
);
	// body image without crc
	function automatic logic [255:0] body();
		logic [255:0] img;
		img = '0;
		img[8*PROM_ID_OFS +: 8] = CARD_ID;
		img[8*PROM_REV_OFS +: 8] = PCB_REV;
		for (int i = 0; i < 6; i++) begin
			img[8*(PROM_STN_OFS+i) +: 8] = STATION[8*(5-i) +: 8];
		end
		img[8*PROM_HI_OFS +: 8] = 8'h01;
		return img;
	endfunction : body

	// reflected crc over bytes below the crc field
	function automatic logic [255:0] image();
		logic [255:0] img;
		logic [31:0]  c;
		img = body();
		c = CRC_INIT;
		for (int i = 0; i < PROM_CRC_OFS; i++) begin
			for (int b = 0; b < 8; b++) begin
				c = (c[0] ^ img[8*i+b]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
			end
		end
		img[8*PROM_CRC_OFS +: 32] = ~c;
		return img;
	endfunction : image

	localparam logic [255:0] ROM = image();

	wire  [7:0] raw = ROM[8*index +: 8];
	logic [7:0] rdata_q;

	// irq flag multiplexed into byte zero, fiq always zero
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= 8'h00;
		end else if (index == 5'(PROM_FLAG_OFS)) begin
			rdata_q <= {7'h00, irq_flag};
		end else begin
			rdata_q <= raw;
		end
	end

	assign rdata = rdata_q;
endmodule : ncb_prom

// File: testbench/ncb_host_model.sv
/*
 host side model: drives the slot select, address and data pins.
 assumes the fixed four state access of the bridge and its two flop inputs.
*/
`timescale 1ns/1ps
module ncb_host_model
	import ncb_pkg::*;
(
	input  wire logic        clk,
	output ncb_slot_type     slot_pins,
	input  wire logic [15:0] slot_data_out,
	input  wire logic        slot_data_oe_n
);
	localparam int DLY = 10; // drive offset after the rising edge

	// idle bus at time zero, select released
	initial begin
		slot_pins = '{sel_n: 1'b1, write_n: 1'b1, addr: 12'h000, wdata: 16'h0000};
	end

	// one access; select is dropped early so the idle state cannot restart
	task automatic access(input logic wr, input logic [11:0] a, input logic [15:0] wd,
		output logic [15:0] rd, output logic ok);
		int n;
		rd = 16'h0000;
		ok = 1'b1;
		@(posedge clk);
		#DLY;
		slot_pins.write_n = ~wr;
		slot_pins.addr = a;
		slot_pins.wdata = wd;
		slot_pins.sel_n = 1'b0;
		repeat (3) @(posedge clk);
		#DLY;
		slot_pins.sel_n = 1'b1;
		if (!wr) begin
			// read data comes with the one cycle output enable
			ok = 1'b0;
			for (n = 0; n < 10 && !ok; n++) begin
				@(posedge clk);
				#1;
				if (slot_data_oe_n === 1'b0) begin
					rd = slot_data_out;
					ok = 1'b1;
				end
			end
		end else begin
			repeat (4) @(posedge clk);
		end
		#DLY;
		// released bus shows the inverse, never the old value
		slot_pins.addr = ~a;
		slot_pins.wdata = ~wd;
	endtask : access
endmodule : ncb_host_model

// File: testbench/ncb_bridge_tb.sv
/*
 self checking bench of the net card host bridge.
 assumes the host model above and drives the controller pins itself.
*/
`timescale 1ns/1ps
module ncb_bridge_tb
	import ncb_pkg::*;
;
	localparam int DLY = 10; // drive offset after the rising edge
	logic         clk, arst_n;
	ncb_slot_type slot_pins;
	ncb_net_type  net_pins;
	logic [15:0]  slot_data_out, net_ad_out, rd;
	logic [1:0]   net_ad_oe_n;
	logic         slot_data_oe_n, net_ready, controller_reset_out;
	logic         loopback_select_bit, attention_pulse, card_irq_n, ok;
	int           fail_count = 0, comparisons = 0;
	int           ready_lows = 0, att_highs = 0, r0, a0;
	logic [7:0]   prom_exp [32];   // expected identity bytes
	logic [15:0]  ctrl_w [4] = '{16'hFFF2, 16'h0004, 16'hFFF5, 16'h0003};

	ncb_bridge ncb_bridge_i (.clk(clk), .arst_n(arst_n), .slot_pins(slot_pins),
		.net_pins(net_pins), .slot_data_out(slot_data_out), .slot_data_oe_n(slot_data_oe_n),
		.net_ad_out(net_ad_out), .net_ad_oe_n(net_ad_oe_n), .net_ready(net_ready),
		.controller_reset_out(controller_reset_out), .loopback_select_bit(loopback_select_bit),
		.attention_pulse(attention_pulse), .card_irq_n(card_irq_n));
	ncb_host_model ncb_host_model_i (.clk(clk), .slot_pins(slot_pins),
		.slot_data_out(slot_data_out), .slot_data_oe_n(slot_data_oe_n));

	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// cycle counters for stall length and pulse width
	always @(posedge clk) begin
		if (net_ready === 1'b0) ready_lows++;
		if (attention_pulse === 1'b1) att_highs++;
	end

	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : final_report

	task automatic check1(string what, logic exp, logic got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask : check1

	task automatic check16(string what, logic [15:0] exp, logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check16

	task automatic done(string t);
		$display("test %s finished, mismatches so far %0d", t, fail_count);
	endtask : done

	// host access; a lost answer ends the run
	task automatic host(logic wr, logic [11:0] a, logic [15:0] wd);
		ncb_host_model_i.access(wr, a, wd, rd, ok);
		if (!ok) begin
			fail_count++;
			final_report();
		end
	endtask : host

	// controller address phase, strobe held three cycles
	task automatic net_addr(logic [15:0] a);
		@(posedge clk);
		#DLY;
		net_pins.ad = a;
		net_pins.ale = 1'b1;
		repeat (3) @(posedge clk);
		#DLY;
		net_pins.ale = 1'b0;
	endtask : net_addr

	task automatic net_write(logic [15:0] a, logic [15:0] d);
		net_addr(a);
		net_pins.ad = d;
		net_pins.wr_n = 1'b0;
		repeat (3) @(posedge clk);
		#DLY;
		net_pins.wr_n = 1'b1;
		repeat (2) @(posedge clk);
		#DLY;
		net_pins.ad = ~d;
	endtask : net_write

	// controller read; bim low masks the upper byte driver
	task automatic net_read(logic [15:0] a, logic bim_n, logic [15:0] exp);
		int n;
		net_addr(a);
		net_pins.ad = ~a;
		net_pins.bim_n = bim_n;
		net_pins.rd_n = 1'b0;
		for (n = 0; n < 12 && net_ad_oe_n[0] !== 1'b0; n++) @(posedge clk);
		if (n == 12) begin
			fail_count++;
			final_report();
		end
		repeat (2) @(posedge clk);
		#1;
		check16("net read data", exp, net_ad_out);
		check16("net data enables", {14'h0000, ~bim_n, 1'b0}, {14'h0000, net_ad_oe_n});
		#DLY;
		net_pins.rd_n = 1'b1;
		net_pins.bim_n = 1'b1;
	endtask : net_read

	// reflected crc over bytes 00..1b, inverted at the end
	function automatic logic [31:0] prom_crc();
		logic [31:0] c;
		c = CRC_INIT;
		for (int i = 0; i < 28; i++) begin
			c = c ^ {24'h00_0000, prom_exp[i]};
			for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return ~c;
	endfunction : prom_crc

	// main sequence
	initial begin
		net_pins = '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, bim_n: 1'b1, intr: 1'b0, ad: 16'h0000};
		arst_n = 1'b0;
		foreach (prom_exp[i]) prom_exp[i] = 8'h00;
		prom_exp[3] = 8'h5A; // arbitrary card code default
		prom_exp[8] = 8'h02;
		prom_exp[9] = 8'h02;
		prom_exp[14] = 8'h01;
		prom_exp[16] = 8'h01;
		{prom_exp[31], prom_exp[30], prom_exp[29], prom_exp[28]} = prom_crc();
		repeat (8) @(posedge clk);
		#DLY;
		arst_n = 1'b1;
		@(posedge clk);
		#1;
		check1("reset out", 1'b1, controller_reset_out);
		check1("loopback", 1'b0, loopback_select_bit);
		check1("attention", 1'b0, attention_pulse);
		check1("irq", 1'b1, card_irq_n);
		check1("ready", 1'b1, net_ready);
		done("reset");
		// control writes, upper bits set to show they are ignored
		foreach (ctrl_w[i]) begin
			r0 = ready_lows;
			a0 = att_highs;
			host(1'b1, 12'h400, ctrl_w[i]);
			check1("reset out", ctrl_w[i][0], controller_reset_out);
			check1("loopback", ctrl_w[i][1], loopback_select_bit);
			check16("pulse cycles", {15'h0000, ctrl_w[i][2]}, 16'(att_highs - a0));
			check16("stall cycles", 16'h0003, 16'(ready_lows - r0));
		end
		host(1'b1, 12'h400, 16'h0000);
		done("control");
		// one word per page at the top of the window
		for (int p = 0; p < 16; p++) begin
			host(1'b1, 12'h200, 16'(p));
			host(1'b1, 12'hFFF, 16'h5A00 + 16'(p));
		end
		for (int p = 0; p < 16; p++) begin
			host(1'b1, 12'h200, 16'(p));
			host(1'b0, 12'hFFF, 16'h0000);
			check16("window word", 16'h5A00 + 16'(p), rd);
		end
		done("pages");
		// controller sees the same ram contiguously; bit zero ignored
		net_read(16'hFFFE, 1'b1, 16'h5A0F);
		net_write(16'hFFF7, 16'hC3A5);
		host(1'b0, 12'hFFB, 16'h0000);
		check16("controller word", 16'hC3A5, rd);
		net_read(16'hFFF6, 1'b0, 16'hC3A5);
		// software duties: configure word, counter reread, init root
		host(1'b1, 12'hFFA, 16'h0001);
		host(1'b0, 12'hFFA, 16'h0000);
		check16("configure word", 16'h0001, rd);
		a0 = att_highs;
		host(1'b1, 12'h400, 16'h0004);
		check16("pulse cycles", 16'h0001, 16'(att_highs - a0));
		host(1'b1, 12'hF00, 16'h0000);
		host(1'b0, 12'hF00, 16'h0000);
		check16("counter reread", 16'h0000, rd);
		// root word with its width bit (bit 0) clear, read in byte mode
		host(1'b1, 12'hFFB, 16'h00FE);
		net_read(16'hFFF6, 1'b0, 16'h00FE);
		done("controller");
		// identity bytes, byte wide on word addresses
		for (int i = 0; i < 32; i++) begin
			host(1'b0, 12'(i), 16'h0000);
			check16("prom byte", {8'h00, prom_exp[i]}, rd);
		end
		ncb_host_model_i.access(1'b0, 12'h600, 16'h0000, rd, ok);
		check1("unmapped answer", 1'b0, ok);
		done("prom");
		// interrupt latch survives a low input and a zero clear bit
		@(posedge clk);
		#DLY;
		net_pins.intr = 1'b1;
		repeat (3) @(posedge clk);
		#DLY;
		net_pins.intr = 1'b0;
		repeat (4) @(posedge clk);
		check1("irq set", 1'b0, card_irq_n);
		host(1'b0, 12'h000, 16'h0000);
		check16("irq flag byte", 16'h0001, rd);
		host(1'b1, 12'h400, 16'hFFF0);
		check1("irq kept", 1'b0, card_irq_n);
		host(1'b1, 12'h400, 16'h0008);
		check1("irq cleared", 1'b1, card_irq_n);
		host(1'b0, 12'h000, 16'h0000);
		check16("flag byte clear", 16'h0000, rd);
		done("interrupt");
		final_report();
	end
endmodule : ncb_bridge_tb
